// ### rtl/uart_defines.svh
// Offsets, field positions, reset values and timing counts of the serial port.
// Assumes a 32-bit bus whose word index is the printed register offset.
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH

// Register indices, byte address is four times the index
`define IDX_CHAR_DATA     3'h0
`define IDX_CONTROL_FLAGS 3'h1
`define IDX_BAUD_DIVIDER  3'h4

// Status and control bit positions
`define BIT_TX_EMPTY  0
`define BIT_TX_FULL   1
`define BIT_RX_FULL   2
`define BIT_RX_AVAIL  3
`define BIT_POLLED    4
`define BIT_OVERRUN   5
`define BIT_FRAMING   6

// Reset values
`define POLLED_RESET  1'b1

// Baud divisor scale
`define DIV_FRAC_BITS 27
`define DIV_RND_SHIFT 5
`define DIV_DEN_SHIFT 4

// Frame timing in 16x ticks
`define TICK_LAST     4'hf
`define TICK_MID      4'h7
`define DATA_LAST     3'h7

// Receive buffer depth
`define RX_DEPTH      2'h2

`endif

// ### rtl/uart_pkg.sv
// Types shared by the serial port.
// Assumes the defines header is compiled alongside.
package uart_pkg;

  // Frame sequencer, Gray codes along the path
  typedef enum logic [1:0] {
    FRAME_IDLE  = 2'b00,
    FRAME_START = 2'b01,
    FRAME_DATA  = 2'b11,
    FRAME_STOP  = 2'b10
  } frame_state_type;

endpackage

// ### rtl/wishbone_serial_uart.sv
// Serial port with a bus slave, 16x baud generator, transmitter and receiver.
// Assumes one bus clock, synchronous reset and a line driver on the pins.
//
// Summary of operation
// R1 - Data register write at offset 0 loads the transmit buffer.
// R2 - Data write waits without acknowledge while transmit buffer is full.
// R3 - Data register read returns the oldest received character.
// R4 - Data read waits without acknowledge while receive buffer is empty.
// R5 - Status bit 0 reads transmit buffer empty.
// R6 - Status bit 1 reads transmit buffer full.
// R7 - Status bit 2 receive buffer full, bit 3 receive data available.
// R8 - Status bit 4 is writable polled mode, disabling interrupts.
// R9 - Status bit 5 reports receiver overrun.
// R10 - Status bit 6 reports receiver framing error.
// R11 - Bus clock divided to a 16x baud tick for both directions.
// R12 - Divisor scaled by two to the 27 over clock/16.
// R13 - Start-up baud rate from a parameter defaulting to 115200.
// R14 - Start-up divisor uses clock frequency parameter in MHz, default 50.
// R15 - Software writes a 32-bit divisor at offset 4.
// R16 - Frames always carry 8 data bits and 1 stop bit.
// R17 - Interrupt only when not polled and a character is waiting.
// R18 - Transmitter never raises the interrupt.
// R19 - Frames driven on transmit pin, sampled on receive pin.
// R20 - Non-stalling masters check transmit empty before writing.
// R21 - Idle high, low start, high stop, LSB first, mid-bit sampling.
// R22 - Stop low sets framing error; push into full buffer sets overrun.
// R23 - Data read pops the buffer; reset empties buffers, loads start divisor.
`include "uart_defines.svh"

module wishbone_serial_uart #(
  parameter int BAUD_RATE            = 115200,
  parameter int bus_clock_freq_param = 50
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             txd_o,
  input  wire logic        rxd_i
);

  // ------------------------------------------------------------
  // Start-up divisor
  // ------------------------------------------------------------
  localparam longint unsigned CLK_HZ    = longint'(bus_clock_freq_param) * 1_000_000;
  localparam longint unsigned START_DIV =
    ((longint'(BAUD_RATE) << `DIV_FRAC_BITS) + (CLK_HZ >> `DIV_RND_SHIFT))
    / (CLK_HZ >> `DIV_DEN_SHIFT); // R12 R13 R14

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic                      ack_q;
  logic [31:0]               dat_q;
  logic                      irq_q;
  logic                      polled_q;
  logic                      overrun_q;
  logic                      framing_q;
  logic [31:0]               div_q;
  logic [26:0]               acc_q;
  logic                      tick_q;
  logic                      tx_full_q;
  logic [7:0]                tx_hold_q;
  uart_pkg::frame_state_type tx_state_q;
  logic [3:0]                tx_cnt_q;
  logic [2:0]                tx_bit_q;
  logic [7:0]                tx_shift_q;
  logic                      txd_q;
  uart_pkg::frame_state_type rx_state_q;
  logic [3:0]                rx_cnt_q;
  logic [2:0]                rx_bit_q;
  logic [7:0]                rx_shift_q;
  logic                      rx_push_q;
  logic                      rx_bad_q;
  logic [7:0]                fifo_mem_q [2];
  logic                      fifo_wr_q;
  logic                      fifo_rd_q;
  logic [1:0]                fifo_cnt_q;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic                      fifo_pop;
  logic                      fifo_push;
  logic                      req;
  logic [2:0]                idx;
  logic                      hit_data;
  logic                      wr_data_ok;
  logic                      rd_data_ok;
  logic                      other_ok;
  logic                      accept;
  logic [32:0]               acc_sum;
  logic [7:0]                status;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign req        = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx        = wb_adr_i[4:2];
  assign hit_data   = (idx == `IDX_CHAR_DATA);
  assign wr_data_ok = req & wb_we_i & hit_data & ~tx_full_q;       // R2
  assign rd_data_ok = req & ~wb_we_i & hit_data & fifo_out_valid;  // R4
  assign other_ok   = req & ~hit_data;
  assign accept     = wr_data_ok | rd_data_ok | other_ok;
  assign fifo_pop   = rd_data_ok;                                  // R23

  always_comb begin
    status                = 8'h00;
    status[`BIT_TX_EMPTY] = ~tx_full_q;                            // R5
    status[`BIT_TX_FULL]  = tx_full_q;                             // R6
    status[`BIT_RX_FULL]  = (fifo_cnt_q == `RX_DEPTH);             // R7
    status[`BIT_RX_AVAIL] = fifo_out_valid;                        // R7
    status[`BIT_POLLED]   = polled_q;                              // R8
    status[`BIT_OVERRUN]  = overrun_q;                             // R9
    status[`BIT_FRAMING]  = framing_q;                             // R10
  end

  // ------------------------------------------------------------
  // Acknowledge and read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= accept;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (accept && !wb_we_i) begin
      if (hit_data) begin
        dat_q <= {24'h00_0000, fifo_mem_q[fifo_rd_q]};             // R3
      end else if (idx == `IDX_CONTROL_FLAGS) begin
        dat_q <= {24'h00_0000, status};
      end else begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Control and error flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      polled_q <= `POLLED_RESET;
    end else if (other_ok && wb_we_i && idx == `IDX_CONTROL_FLAGS && wb_sel_i[0]) begin
      polled_q <= wb_dat_i[`BIT_POLLED];                           // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
    end else begin
      if (other_ok && !wb_we_i && idx == `IDX_CONTROL_FLAGS) begin
        overrun_q <= 1'b0;
        framing_q <= 1'b0;
      end
      if (rx_push_q && !fifo_in_ready) begin
        overrun_q <= 1'b1;                                         // R22
      end
      if (rx_push_q && rx_bad_q) begin
        framing_q <= 1'b1;                                         // R22
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ~polled_q & fifo_out_valid;                         // R17 R18
    end
  end

  // ------------------------------------------------------------
  // Baud generator
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= START_DIV[31:0];                                    // R23
    end else if (other_ok && wb_we_i && idx == `IDX_BAUD_DIVIDER) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          div_q[8*i +: 8] <= wb_dat_i[8*i +: 8];                   // R15
        end
      end
    end
  end

  assign acc_sum = {6'h00, acc_q} + {1'b0, div_q};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_q  <= 27'h000_0000;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_sum[26:0];                                     // R12
      tick_q <= |acc_sum[32:27];                                   // R11
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer and sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_full_q <= 1'b0;
      tx_hold_q <= 8'h00;
    end else if (wr_data_ok && wb_sel_i[0]) begin
      tx_full_q <= 1'b1;                                           // R1
      tx_hold_q <= wb_dat_i[7:0];
    end else if (tx_state_q == uart_pkg::FRAME_IDLE) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_state_q <= uart_pkg::FRAME_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      txd_q      <= 1'b1;
    end else begin
      unique case (tx_state_q)
        uart_pkg::FRAME_IDLE: begin
          txd_q <= 1'b1;
          if (tx_full_q) begin
            tx_shift_q <= tx_hold_q;
            tx_cnt_q   <= 4'h0;
            txd_q      <= 1'b0;                                    // R21
            tx_state_q <= uart_pkg::FRAME_START;
          end
        end
        uart_pkg::FRAME_START: begin
          if (tick_q) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == `TICK_LAST) begin
              txd_q      <= tx_shift_q[0];                         // R21
              tx_bit_q   <= 3'h0;
              tx_state_q <= uart_pkg::FRAME_DATA;
            end
          end
        end
        uart_pkg::FRAME_DATA: begin
          if (tick_q) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == `TICK_LAST) begin
              if (tx_bit_q == `DATA_LAST) begin
                txd_q      <= 1'b1;                                // R16
                tx_state_q <= uart_pkg::FRAME_STOP;
              end else begin
                tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                txd_q      <= tx_shift_q[1];
                tx_bit_q   <= tx_bit_q + 3'h1;
              end
            end
          end
        end
        uart_pkg::FRAME_STOP: begin
          if (tick_q) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == `TICK_LAST) begin
              tx_state_q <= uart_pkg::FRAME_IDLE;                  // R16
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receive sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_state_q <= uart_pkg::FRAME_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_push_q  <= 1'b0;
      rx_bad_q   <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      unique case (rx_state_q)
        uart_pkg::FRAME_IDLE: begin
          if (tick_q && !rxd_i) begin                              // R19
            rx_cnt_q   <= 4'h0;
            rx_state_q <= uart_pkg::FRAME_START;
          end
        end
        uart_pkg::FRAME_START: begin
          if (tick_q) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `TICK_MID) begin
              rx_cnt_q   <= 4'h0;
              rx_bit_q   <= 3'h0;
              rx_state_q <= rxd_i ? uart_pkg::FRAME_IDLE : uart_pkg::FRAME_DATA; // R21
            end
          end
        end
        uart_pkg::FRAME_DATA: begin
          if (tick_q) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `TICK_LAST) begin
              rx_shift_q <= {rxd_i, rx_shift_q[7:1]};              // R21
              rx_bit_q   <= rx_bit_q + 3'h1;
              if (rx_bit_q == `DATA_LAST) begin
                rx_state_q <= uart_pkg::FRAME_STOP;                // R16
              end
            end
          end
        end
        uart_pkg::FRAME_STOP: begin
          if (tick_q) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `TICK_LAST) begin
              rx_push_q  <= 1'b1;
              rx_bad_q   <= ~rxd_i;                                // R22
              rx_state_q <= uart_pkg::FRAME_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Two-entry receive buffer
  // ------------------------------------------------------------
  assign fifo_in_ready  = (fifo_cnt_q != `RX_DEPTH);
  assign fifo_out_valid = (fifo_cnt_q != 2'h0);
  assign fifo_push      = rx_push_q & fifo_in_ready;

  always_ff @(posedge clk_i) begin
    if (fifo_push) begin
      fifo_mem_q[fifo_wr_q] <= rx_shift_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fifo_wr_q  <= 1'b0;
      fifo_rd_q  <= 1'b0;
      fifo_cnt_q <= 2'h0;                                          // R23
    end else begin
      if (fifo_push) begin
        fifo_wr_q <= ~fifo_wr_q;
      end
      if (fifo_pop) begin
        fifo_rd_q <= ~fifo_rd_q;                                   // R23
      end
      fifo_cnt_q <= fifo_cnt_q + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o    = irq_q;
  assign txd_o    = txd_q;                                         // R19

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_tx_leave_idle;
    tx_state_q == uart_pkg::FRAME_IDLE && tx_full_q;
  endsequence

  sequence s_start_low;
    !txd_o && tx_state_q == uart_pkg::FRAME_START;
  endsequence

  a_write_stall_full: assert property ( // R2
    (req && wb_we_i && hit_data && tx_full_q) |=> !wb_ack_o)
    else $error("data write acknowledged while transmit buffer full");

  a_read_stall_empty: assert property ( // R4
    (req && !wb_we_i && hit_data && fifo_cnt_q == 2'h0) |=> !wb_ack_o)
    else $error("data read acknowledged while receive buffer empty");

  a_write_loads_tx: assert property ( // R1
    (wr_data_ok && wb_sel_i[0]) |=> tx_full_q && tx_hold_q == $past(wb_dat_i[7:0]))
    else $error("accepted write did not load transmit buffer");

  a_irq_cause_only: assert property ( // R17
    irq_o |-> !$past(polled_q) && $past(fifo_cnt_q) != 2'h0)
    else $error("interrupt without waiting character in interrupt mode");

  a_tx_no_irq: assert property ( // R18
    (fifo_cnt_q == 2'h0 && $stable(fifo_cnt_q)) |=> !irq_o)
    else $error("interrupt raised with empty receive buffer");

  a_status_tx_bits: assert property ( // R5
    (other_ok && !wb_we_i && idx == `IDX_CONTROL_FLAGS)
      |=> wb_dat_o[`BIT_TX_EMPTY] == !$past(tx_full_q)
          && wb_dat_o[`BIT_TX_FULL] == $past(tx_full_q))
    else $error("status transmit bits wrong");

  a_frame_start_low: assert property ( // R21
    s_tx_leave_idle |=> s_start_low)
    else $error("frame did not begin with low start bit");

  a_stop_bit_high: assert property ( // R16
    tx_state_q == uart_pkg::FRAME_STOP |-> txd_o)
    else $error("stop bit not high");

  a_overrun_set: assert property ( // R22
    (rx_push_q && fifo_cnt_q == `RX_DEPTH) |=> overrun_q)
    else $error("overrun not flagged");

  a_read_pops: assert property ( // R23
    (rd_data_ok && !rx_push_q) |=> fifo_cnt_q == $past(fifo_cnt_q) - 2'h1)
    else $error("data read did not remove a character");

  a_div_write: assert property ( // R15
    (other_ok && wb_we_i && idx == `IDX_BAUD_DIVIDER && wb_sel_i == 4'hf)
      |=> div_q == $past(wb_dat_i))
    else $error("divisor write not taken");

endmodule

// ### test/serial_peer.sv
// Far side of the serial link: drives the receive pin, collects transmit frames.
// Assumes the divisor gives one 16x tick per bus clock.
module serial_peer #(
  parameter int BIT_CYC = 16  // Clocks per bit at divisor 0x0800_0000
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] got_q[$];
  logic [7:0] d;

  initial rxd_o = 1'b1;

  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  task automatic send(input logic [7:0] c, input logic stop);
    logic [9:0] f;
    f = {stop, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      rxd_o = f[i];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    rxd_o = 1'b1;
  endtask

  // ----------------------------------------
  // Frame collector, mid-bit sampling
  // ----------------------------------------
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      d[i] = txd_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    got_q.push_back({txd_i, d});
  end
endmodule

// ### test/test_wishbone_serial_uart.sv
// Self-checking bench for the serial port, register accesses and serial peer.
// Assumes the design and the serial peer model are compiled first.
module test_wishbone_serial_uart;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_DATA = 32'h0000_0000;
  localparam logic [31:0] A_CTRL = 32'h0000_0004;
  localparam logic [31:0] A_DIV  = 32'h0000_0010;

  logic        clk_i;
  logic        srst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [31:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        txd_o;
  logic        rxd;
  logic [31:0] rd;
  logic [7:0]  txv[3];
  int          fails;
  int          check_count;

  wishbone_serial_uart uut (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i (wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .irq_o   (irq_o),
    .txd_o   (txd_o),
    .rxd_i   (rxd)
  );

  serial_peer peer (
    .clk_i(clk_i),
    .txd_i(txd_o),
    .rxd_o(rxd)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Checks and bus access
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task bus(input logic we, input logic [31:0] adr, input logic [31:0] dat,
           input logic [3:0] sel);
    int n;
    @(negedge clk_i);
    wb_cyc_i = 1'b1;
    wb_stb_i = 1'b1;
    wb_we_i  = we;
    wb_adr_i = adr;
    wb_dat_i = dat;
    wb_sel_i = sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20000);
    rd = wb_dat_o;
    chk({31'h0, wb_ack_o}, 32'h0000_0001, "acknowledge");
    @(negedge clk_i);
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
  endtask

  task rd_chk(input logic [31:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0000_0000, 4'hf);
    chk(rd, exp, what);
  endtask

  task wait_frames(input int n);
    for (int i = 0; i < 5000 && peer.got_q.size() < n; i++) @(posedge clk_i);
    chk({31'h0, peer.got_q.size() >= n}, 32'h0000_0001, "frames arrived");
  endtask

  task results;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    srst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0000_0000;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    fails = 0;
    check_count = 0;
    txv = '{8'hA5, 8'h3C, 8'h96};
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    chk({31'h0, irq_o}, 32'h0000_0000, "irq after reset");
    chk(uut.div_q, 32'h004B_7F5A, "start divisor");
    rd_chk(A_CTRL, 32'h0000_0011, "status after reset");
    rd_chk(A_DIV, 32'h0000_0000, "divisor readback");
    rd_chk(32'h0000_000C, 32'h0000_0000, "unmapped read");
    $display("test reset done");

    bus(1'b1, A_DIV, 32'h0800_0000, 4'hf);
    bus(1'b1, A_DATA, {24'h0, txv[0]}, 4'h1);
    bus(1'b1, A_DATA, {24'h0, txv[1]}, 4'h1);
    rd_chk(A_CTRL, 32'h0000_0012, "tx full");
    bus(1'b1, A_DATA, {24'h0, txv[2]}, 4'h1);
    chk({31'h0, peer.got_q.size() >= 1}, 32'h0000_0001, "write stalled");
    rd = 32'h0000_0000;
    for (int i = 0; i < 100 && rd[0] !== 1'b1; i++) bus(1'b0, A_CTRL, 32'h0, 4'hf);
    chk({31'h0, rd[0]}, 32'h0000_0001, "tx empty seen");
    wait_frames(3);
    foreach (txv[i]) chk(32'(peer.got_q.pop_front()), {23'h0, 1'b1, txv[i]}, "frame");
    $display("test transmit done");

    peer.send(8'h5A, 1'b1);
    repeat (4) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq while polled");
    rd_chk(A_CTRL, 32'h0000_0019, "rx available");
    bus(1'b1, A_CTRL, 32'h0000_0000, 4'h1);
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq raised");
    rd_chk(A_CTRL, 32'h0000_0009, "polled cleared");
    rd_chk(A_DATA, 32'h0000_005A, "rx char");
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq after read");
    rd = 32'hFFFF_FFFF;
    fork
      rd_chk(A_DATA, 32'h0000_00C3, "blocked read");
      begin
        repeat (20) @(negedge clk_i);
        chk(rd, 32'hFFFF_FFFF, "read still blocked");
        peer.send(8'hC3, 1'b1);
      end
    join
    $display("test receive done");

    bus(1'b1, A_DATA, 32'h0000_007E, 4'h1);
    wait_frames(1);
    chk({31'h0, irq_o}, 32'h0000_0000, "tx no irq");
    chk(32'(peer.got_q.pop_front()), 32'h0000_017E, "frame");
    $display("test tx irq done");

    peer.send(8'h81, 1'b0);
    repeat (4) @(negedge clk_i);
    rd_chk(A_CTRL, 32'h0000_0049, "framing flag");
    rd_chk(A_DATA, 32'h0000_0081, "framed char");
    rd_chk(A_CTRL, 32'h0000_0001, "flags cleared");
    $display("test framing done");

    peer.send(8'h11, 1'b1);
    peer.send(8'h22, 1'b1);
    peer.send(8'h33, 1'b1);
    repeat (4) @(negedge clk_i);
    rd_chk(A_CTRL, 32'h0000_002D, "overrun");
    rd_chk(A_DATA, 32'h0000_0011, "first kept");
    rd_chk(A_DATA, 32'h0000_0022, "second kept");
    rd_chk(A_CTRL, 32'h0000_0001, "buffer empty");
    $display("test overrun done");
    results;
  end
endmodule
